// file: design/swp_pkg.sv
// ============================================================
// shared constants of the serial port
package swp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W = 7;
    localparam int CLK_PERIOD_NS = 100;
    // ============================================================
    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL3 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
    // ============================================================
    // field positions
    localparam int C1_MASTER = 0;
    localparam int C1_PHASE = 1;
    localparam int C1_IDLE = 2;
    localparam int C1_EN = 3;
    localparam int C3_BUFLEN = 0;
    localparam int C3_READY = 1;
    localparam int C3_ECHO = 2;
    localparam int C3_OVR_IE = 3;
    localparam int C3_RD_IE = 4;
    localparam int C3_WR_IE = 5;
    localparam int ST_BUSY = 0;
    localparam int ST_RBF = 1;
    localparam int ST_OVR = 2;
    // ============================================================
    // reset values and bus answers
    localparam logic [3:0] CTRL1_RST = 4'h0;
    localparam logic [DIV_W-1:0] CTRL2_RST = 7'h00;
    localparam logic [5:0] CTRL3_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] EDGE_LAST = 4'hF;
    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_WAIT = 3'b010,
        M_RUN = 3'b100
    } swp_mst_e;
endpackage

// file: design/swp_sync.sv
`timescale 1ns/1ps
// ============================================================
// two-stage synchroniser for pins from outside clk_sys
module swp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            synced <= RST_VAL;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule // swp_sync

// file: design/swp_top.sv
`timescale 1ns/1ps
// What this block does
// - one master drives shift clock and starts transfers; slaves follow that clock
// - master sends on mosi, receives on miso; slave swaps line roles
// - one 8-bit shifter sends and receives together, msb first
// - one bit out and one bit in per shift clock cycle
// - data read returns read buffer; data write loads shifter only
// - shifter copies to read buffer when done and buffer already read
// - master: overrun when transfer starts with buffer and shifter both unread
// - read_buffer_full shows unread data; overrun_flag sticks once overrun happens
// - clock_phase_select picks mode; idle level and divider set shift clock
// - bit 6 on second leading edge, or on first trailing edge
// - master data write starts exactly eight shift clocks, then idle
// - master start delay half to 1.5 periods, or zero to one
// - slave: clock is input; miso and ready released while deselected
// - slave drives miso on select, msb first; done after eight clocks
// - slave echoes incoming bits if unwritten and echo enabled, else shifter
// - ready inactive at reset, set by software, cleared after each byte
// - interrupt while read_buffer_full and read_irq_enable
// - interrupt while busy_flag clear and write_irq_enable
// - interrupt when overrun_flag set and overrun_irq_enable
// - normal: output on falling, sample rising; alternate reverses both
// - master_select zero is slave, one is master
module swp_top
    import swp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic shiftClockRx,
    output logic shiftClockTx,
    output logic shiftClockOe,
    input wire logic masterOutSlaveInRx,
    output logic masterOutSlaveInTx,
    output logic masterOutSlaveInOe,
    input wire logic masterInSlaveOutRx,
    output logic masterInSlaveOutTx,
    output logic masterInSlaveOutOe,
    input wire logic slaveSelectN,
    output logic slaveReadyN,
    output logic slaveReadyOe,
    output logic irq
);
    // ============================================================
    // registers and state
    logic masterSelect_q, clockPhaseSelect_q, clockIdleLevel_q, enable_q;
    logic [DIV_W-1:0] clockDividerValue_q;
    logic slaveBufferLength_q, echoBackEnable_q;
    logic overrunIrqEnable_q, readIrqEnable_q, writeIrqEnable_q;
    logic [7:0] shifter_q, readBuffer_q;
    logic readBufferFull_q, shifterFull_q, overrunFlag_q, busyFlag_q;
    logic rxBit_q, pend_q, echo_q, txValid_q, readyActive_q, doneLoad_q, txBit_q;
    logic [2:0] bitCnt_q;
    logic [3:0] edgeCnt_q;
    logic [DIV_W-1:0] divCnt_q;
    logic sckLevel_q, sckPrev_q;
    swp_mst_e mState_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic sckS, selNS, mosiS, misoS;

    // ============================================================
    // pin synchronisers
    swp_sync #(.W(4), .RST_VAL(4'h2)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async({shiftClockRx, slaveSelectN, masterOutSlaveInRx, masterInSlaveOutRx}),
        .synced({sckS, selNS, mosiS, misoS})
    );

    // ============================================================
    // register bus
    logic wrFire, rdFire, wrData, rdPop, wrCtrl3, wrStat;
    logic [7:0] wByte;

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return a == OFS_DATA || a == OFS_CTRL1 || a == OFS_CTRL2 || a == OFS_CTRL3 || a == OFS_STAT;
    endfunction

    // both channels are taken together, so order between them never matters
    assign wrFire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign rdFire = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign wByte = s_axi_wdata[7:0];
    assign wrData = wrFire && s_axi_wstrb[0] && s_axi_awaddr == OFS_DATA;
    assign wrCtrl3 = wrFire && s_axi_wstrb[0] && s_axi_awaddr == OFS_CTRL3;
    assign wrStat = wrFire && s_axi_wstrb[0] && s_axi_awaddr == OFS_STAT;
    assign rdPop = rdFire && s_axi_araddr == OFS_DATA;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wrFire) begin
            bvalid_q <= 1'b1;
            bresp_q <= isMapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (rdFire) begin
            rvalid_q <= 1'b1;
            rresp_q <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_DATA: rdata_q <= {24'h00_0000, readBuffer_q};
                OFS_CTRL1: rdata_q <= {28'h000_0000, enable_q, clockIdleLevel_q,
                                       clockPhaseSelect_q, masterSelect_q};
                OFS_CTRL2: rdata_q <= {25'h000_0000, clockDividerValue_q};
                OFS_CTRL3: rdata_q <= {26'h000_0000, writeIrqEnable_q, readIrqEnable_q,
                                       overrunIrqEnable_q, echoBackEnable_q, 1'b0, slaveBufferLength_q};
                OFS_STAT: rdata_q <= {29'h0000_0000, overrunFlag_q, readBufferFull_q, busyFlag_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {enable_q, clockIdleLevel_q, clockPhaseSelect_q, masterSelect_q} <= CTRL1_RST;
            clockDividerValue_q <= CTRL2_RST;
            {writeIrqEnable_q, readIrqEnable_q, overrunIrqEnable_q, echoBackEnable_q} <= CTRL3_RST[5:2];
            slaveBufferLength_q <= CTRL3_RST[0];
        end else if (wrFire && s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
                OFS_CTRL1: begin
                    masterSelect_q <= wByte[C1_MASTER];
                    clockPhaseSelect_q <= wByte[C1_PHASE];
                    clockIdleLevel_q <= wByte[C1_IDLE];
                    enable_q <= wByte[C1_EN];
                end
                OFS_CTRL2: clockDividerValue_q <= wByte[DIV_W-1:0];
                OFS_CTRL3: begin
                    slaveBufferLength_q <= wByte[C3_BUFLEN];
                    echoBackEnable_q <= wByte[C3_ECHO];
                    overrunIrqEnable_q <= wByte[C3_OVR_IE];
                    readIrqEnable_q <= wByte[C3_RD_IE];
                    writeIrqEnable_q <= wByte[C3_WR_IE];
                end
                default: ;
            endcase
        end
    end

    // ============================================================
    // master clock generator
    logic sampleLeading, mEdge, mFinish, mStart;
    logic [DIV_W-1:0] halfReload;

    // normal mode samples on the rising edge, so sampling is leading when idle is low
    assign sampleLeading = clockPhaseSelect_q == clockIdleLevel_q;
    assign halfReload = clockDividerValue_q;
    assign mStart = wrData && masterSelect_q && enable_q;
    assign mEdge = mState_q == M_RUN && divCnt_q == '0;
    assign mFinish = mEdge && edgeCnt_q == EDGE_LAST;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable_q || !masterSelect_q) begin
            mState_q <= M_IDLE;
            divCnt_q <= '0;
            edgeCnt_q <= 4'h0;
        end else begin
            case (mState_q)
                M_IDLE: begin
                    if (mStart) begin
                        mState_q <= M_WAIT;
                        divCnt_q <= sampleLeading ? halfReload : '0;
                        edgeCnt_q <= 4'h0;
                    end
                end
                M_WAIT: begin
                    if (divCnt_q == '0) begin
                        mState_q <= M_RUN;
                    end else begin
                        divCnt_q <= divCnt_q - 1'b1;
                    end
                end
                M_RUN: begin
                    if (mEdge) begin
                        divCnt_q <= halfReload;
                        edgeCnt_q <= edgeCnt_q + 1'b1;
                        if (mFinish) begin
                            mState_q <= M_IDLE;
                        end
                    end else begin
                        divCnt_q <= divCnt_q - 1'b1;
                    end
                end
                default: mState_q <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sckLevel_q <= 1'b0;
        end else if (mState_q != M_RUN) begin
            sckLevel_q <= clockIdleLevel_q;
        end else if (mEdge) begin
            sckLevel_q <= !sckLevel_q;
        end
    end

    // ============================================================
    // slave edge detection on synchronised pins
    logic selActive, sEdge, sRise, sDone;

    assign selActive = !selNS && !masterSelect_q && enable_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sckPrev_q <= 1'b0;
        end else begin
            sckPrev_q <= sckS;
        end
    end
    assign sEdge = selActive && sckS != sckPrev_q;
    assign sRise = sckS;

    // ============================================================
    // shared shift engine
    logic evEdge, evRise, evSample, evShift, dataIn, xferDone;

    assign evEdge = masterSelect_q ? mEdge : sEdge;
    assign evRise = masterSelect_q ? !sckLevel_q : sRise;
    assign dataIn = masterSelect_q ? misoS : mosiS;
    assign evSample = evEdge && (evRise != clockPhaseSelect_q);
    assign evShift = evEdge && (evRise == clockPhaseSelect_q);
    assign sDone = !masterSelect_q && evSample && bitCnt_q == BIT_LAST;
    assign xferDone = masterSelect_q ? mFinish : sDone;

    // a shift edge only moves data after a sample, so the msb stays up through
    // a leading shift edge and bit 6 lands where the two clocking modes expect
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shifter_q <= 8'h00;
            rxBit_q <= 1'b0;
            pend_q <= 1'b0;
            bitCnt_q <= 3'h0;
        end else if (wrData) begin
            shifter_q <= wByte;
            pend_q <= 1'b0;
            bitCnt_q <= 3'h0;
        end else if (!masterSelect_q && !selActive) begin
            pend_q <= 1'b0;
            bitCnt_q <= 3'h0;
        end else if (evSample && bitCnt_q == BIT_LAST) begin
            shifter_q <= {shifter_q[6:0], dataIn};
            pend_q <= 1'b0;
            bitCnt_q <= 3'h0;
        end else if (evSample) begin
            rxBit_q <= dataIn;
            pend_q <= 1'b1;
            bitCnt_q <= bitCnt_q + 1'b1;
        end else if (evShift && pend_q) begin
            shifter_q <= {shifter_q[6:0], rxBit_q};
            pend_q <= 1'b0;
        end
    end

    // the data line holds on sample edges: the last sample loads the shifter,
    // and the far side samples on that same edge, so the pin must not follow it there
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txBit_q <= 1'b0;
        end else if (wrData) begin
            txBit_q <= wByte[7];
        end else if (evShift && pend_q) begin
            txBit_q <= shifter_q[6];
        end else if (!evSample) begin
            txBit_q <= shifter_q[7];
        end
    end

    // ============================================================
    // read buffer, status flags
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            doneLoad_q <= 1'b0;
        end else begin
            doneLoad_q <= xferDone;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable_q) begin
            readBuffer_q <= 8'h00;
            readBufferFull_q <= 1'b0;
            shifterFull_q <= 1'b0;
        end else if (doneLoad_q && (!readBufferFull_q || rdPop)) begin
            readBuffer_q <= shifter_q;
            readBufferFull_q <= 1'b1;
        end else if (doneLoad_q) begin
            shifterFull_q <= 1'b1;
        end else if (rdPop && shifterFull_q) begin
            readBuffer_q <= shifter_q;
            shifterFull_q <= 1'b0;
        end else if (rdPop) begin
            readBufferFull_q <= 1'b0;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable_q) begin
            overrunFlag_q <= 1'b0;
        end else if (mStart && readBufferFull_q && shifterFull_q) begin
            overrunFlag_q <= 1'b1;
        end else if (wrStat && wByte[ST_OVR]) begin
            overrunFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !enable_q) begin
            busyFlag_q <= 1'b0;
        end else if (mStart || (!masterSelect_q && evSample)) begin
            busyFlag_q <= 1'b1;
        end else if (doneLoad_q || (!masterSelect_q && !selActive)) begin
            busyFlag_q <= 1'b0;
        end
    end

    // ============================================================
    // slave echo and ready
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txValid_q <= 1'b0;
            echo_q <= 1'b0;
        end else begin
            if (wrData) begin
                txValid_q <= 1'b1;
            end else if (xferDone) begin
                txValid_q <= 1'b0;
            end
            // decision is frozen once the slave transfer is under way
            if (!busyFlag_q) begin
                echo_q <= echoBackEnable_q && !txValid_q && !wrData;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            readyActive_q <= 1'b0;
        end else if (wrCtrl3 && wByte[C3_READY] && !masterSelect_q) begin
            readyActive_q <= 1'b1;
        end else if (sDone) begin
            readyActive_q <= 1'b0;
        end
    end

    // ============================================================
    // pins and interrupt
    assign shiftClockTx = sckLevel_q;
    assign shiftClockOe = masterSelect_q;
    assign masterOutSlaveInTx = txBit_q;
    assign masterOutSlaveInOe = masterSelect_q;
    // echo uses the synchronised input, so the echoed bit lags the pin by two clocks
    assign masterInSlaveOutTx = echo_q ? mosiS : txBit_q;
    assign masterInSlaveOutOe = selActive;
    assign slaveReadyN = !readyActive_q;
    assign slaveReadyOe = selActive;
    assign irq = (readBufferFull_q && readIrqEnable_q)
        || (!busyFlag_q && writeIrqEnable_q)
        || (overrunFlag_q && overrunIrqEnable_q);

    // ============================================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence sDoneSeen;
        xferDone && !readBufferFull_q && enable_q && !rdPop;
    endsequence
    sequence sBufLoaded;
        ##2 readBufferFull_q && readBuffer_q == $past(shifter_q);
    endsequence
    sequence sPopFromShifter;
        rdPop && shifterFull_q && readBufferFull_q && !doneLoad_q && enable_q;
    endsequence

    a_buf_load: assert property (sDoneSeen |-> sBufLoaded)
        else $error("shifter not moved to read buffer");
    a_pop_refill: assert property (sPopFromShifter |=> readBufferFull_q && !shifterFull_q)
        else $error("pending byte not moved on read");
    a_ovr_set: assert property (mStart && readBufferFull_q && shifterFull_q |=> overrunFlag_q)
        else $error("overrun not flagged");
    a_busy_start: assert property (mStart |=> busyFlag_q && mState_q == M_WAIT)
        else $error("master write did not start burst");
    a_idle_level: assert property (mState_q == M_IDLE && $stable(clockIdleLevel_q) [*2]
        |-> shiftClockTx == clockIdleLevel_q)
        else $error("shift clock not at idle level");
    a_miso_release: assert property (!selActive |-> !masterInSlaveOutOe && !slaveReadyOe)
        else $error("slave outputs driven while deselected");
    a_ready_drop: assert property (sDone && !(wrCtrl3 && wByte[C3_READY]) |=> slaveReadyN)
        else $error("ready not released after byte");
    a_irq_read: assert property (readBufferFull_q && readIrqEnable_q |-> irq)
        else $error("read interrupt missing");
    a_irq_write: assert property ($fell(busyFlag_q) && writeIrqEnable_q |-> irq)
        else $error("write interrupt missing");
    a_msb_first: assert property (mStart |=> masterOutSlaveInTx == $past(s_axi_wdata[7]))
        else $error("msb not presented first");
endmodule // swp_top

// file: tb/swp_partner.sv
`timescale 1ns/1ps
// ============================================================
// far side of the link: a slave while the port masters, a master otherwise
module swp_partner (
    input wire logic phase,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic [7:0] sTx,
    input wire logic arm,
    output logic pSck,
    output logic pMosi,
    output logic pMiso,
    output logic pCsN,
    output logic [7:0] rxByte,
    output int nEdge
);
    logic [7:0] sr = '0;
    initial begin
        pSck = 1'b0;
        pMosi = 1'b0;
        pCsN = 1'b1;
        rxByte = '0;
        nEdge = 0;
    end
    assign pMiso = sr[7];
    always @(posedge arm) begin
        sr = sTx;
        nEdge = 0;
    end
    // a shift-side edge before the first sample is skipped so bit 7 stays up until it is sampled
    task automatic step(input logic smp);
        if (smp) begin
            rxByte = {rxByte[6:0], mosi};
            nEdge++;
        end else if (nEdge > 0)
            sr = {sr[6:0], 1'b0};
    endtask
    always @(posedge sck) if (pCsN) step(!phase);
    always @(negedge sck) if (pCsN) step(phase);
    // clock stands still outside frames; odd start offset keeps it off the system phase
    task automatic mst_xfer(input logic [7:0] b);
        #37;
        pCsN = 1'b0;
        #1600;
        for (int i = 7; i >= 0; i--) begin
            pMosi = b[i];
            #400;
            pSck = 1'b1;
            rxByte = {rxByte[6:0], miso};
            #400;
            pSck = 1'b0;
        end
        #800;
        pCsN = 1'b1;
    endtask
endmodule // swp_partner

// file: tb/test_swp_top.sv
`timescale 1ns/1ps
module test_swp_top;
    import swp_pkg::*;
    logic clk_sys = 0, rst_n = 0, awV = 0, wV = 0, arV = 0, ph = 0, arm = 0;
    logic [ADDR_W-1:0] awA = '0, arA = '0;
    logic [DATA_W-1:0] wD = '0, rD, v;
    logic awRdy, wRdy, bV, arRdy, rV, sckTx, sckOe, moTx, moOe, miTx, miOe, rdyN, rdyOe, irq;
    logic pSck, pMosi, pMiso, pCsN;
    logic [1:0] bResp, rResp;
    logic [7:0] sTx = '0, pRx;
    int nEdge, n_errors = 0, num_checks = 0;
    wire sck = sckOe ? sckTx : pSck;
    wire mosi = moOe ? moTx : pMosi;
    wire miso = miOe ? miTx : pMiso;
    always #50 clk_sys = ~clk_sys;
    swp_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
        .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
        .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
        .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(1'b1), .shiftClockRx(sck),
        .shiftClockTx(sckTx), .shiftClockOe(sckOe), .masterOutSlaveInRx(mosi), .masterOutSlaveInTx(moTx),
        .masterOutSlaveInOe(moOe), .masterInSlaveOutRx(miso), .masterInSlaveOutTx(miTx), .masterInSlaveOutOe(miOe),
        .slaveSelectN(pCsN), .slaveReadyN(rdyN), .slaveReadyOe(rdyOe), .irq(irq));
    swp_partner P (.phase(ph), .sck(sck), .mosi(mosi), .miso(miso), .sTx(sTx), .arm(arm), .pSck(pSck),
        .pMosi(pMosi), .pMiso(pMiso), .pCsN(pCsN), .rxByte(pRx), .nEdge(nEdge));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ready lines stay high, so a response is taken on the edge it shows
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        do @(posedge clk_sys); while (!(awRdy === 1'b1 && wRdy === 1'b1));
        awV <= 1'b0;
        wV <= 1'b0;
        do @(posedge clk_sys); while (bV !== 1'b1);
        chk("bresp", bResp, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        arA <= a;
        arV <= 1'b1;
        do @(posedge clk_sys); while (arRdy !== 1'b1);
        arV <= 1'b0;
        do @(posedge clk_sys); while (rV !== 1'b1);
        d = rD;
        chk("rresp", rResp, er);
    endtask
    task automatic mxfer(input logic [7:0] tx, input logic [7:0] back);
        sTx <= back;
        @(posedge clk_sys);
        arm <= 1'b1;
        @(posedge clk_sys);
        arm <= 1'b0;
        wr(OFS_DATA, tx);
        for (int i = 0; i < 100; i++) begin
            rd(OFS_STAT, v);
            if (v[ST_BUSY] === 1'b0) break;
        end
        repeat (4) @(posedge clk_sys);
        chk("clock count", nEdge, 8);
        chk("byte at far side", pRx, tx);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("ready pin", rdyN, 1'h1);
        chk("enables", {irq, sckOe, moOe, miOe, rdyOe}, '0);
        rd(OFS_CTRL1, v);
        chk("ctrl1", v, CTRL1_RST);
        rd(OFS_STAT, v);
        chk("status", v, '0);
        rd(8'h14, v, RESP_SLVERR);
        chk("unmapped", v, '0);
        wr(8'h14, 32'h0000_0001, RESP_SLVERR);
        wr(OFS_CTRL2, 32'h0000_0003);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL1, 32'h0000_0009 | (m << 1));
            ph <= m[0];
            mxfer(8'hA5 ^ m[7:0], 8'h3C + m[7:0]);
            chk("idle level", sck, m[1]);
            rd(OFS_STAT, v);
            chk("buffer full", v[ST_RBF], 1'h1);
            rd(OFS_DATA, v);
            chk("read data", v, 8'h3C + m[7:0]);
        end
        wr(OFS_CTRL3, 32'h0000_0020);
        chk("write irq", irq, 1'h1);
        wr(OFS_CTRL3, 32'h0000_0018);
        chk("no irq", irq, 1'h0);
        mxfer(8'h11, 8'h81);
        chk("read irq", irq, 1'h1);
        mxfer(8'h22, 8'h82);
        mxfer(8'h33, 8'h83);
        rd(OFS_STAT, v);
        chk("overrun", v[ST_OVR], 1'h1);
        wr(OFS_CTRL3, 32'h0000_0008);
        chk("overrun irq", irq, 1'h1);
        rd(OFS_DATA, v);
        chk("first byte kept", v, 8'h81);
        wr(OFS_CTRL1, 32'h0000_0000);
        rd(OFS_STAT, v);
        chk("flags cleared", v, '0);
        wr(OFS_CTRL1, 32'h0000_0008);
        wr(OFS_CTRL3, 32'h0000_0000);
        wr(OFS_DATA, 8'h5A);
        wr(OFS_CTRL3, 32'h0000_0002);
        chk("ready set", rdyN, 1'h0);
        chk("miso released", {miOe, rdyOe, sckOe}, '0);
        P.mst_xfer(8'hC3);
        repeat (6) @(posedge clk_sys);
        chk("slave sent", pRx, 8'h5A);
        chk("ready dropped", rdyN, 1'h1);
        rd(OFS_DATA, v);
        chk("slave received", v, 8'hC3);
        wr(OFS_CTRL3, 32'h0000_0004);
        P.mst_xfer(8'h96);
        repeat (6) @(posedge clk_sys);
        chk("echoed", pRx, 8'h96);
        rd(OFS_DATA, v);
        chk("echo received", v, 8'h96);
        tally_and_finish;
    end
endmodule // test_swp_top
